// ==== rtl/actc_timing.sv ====
// converter timing control: apb registers, prescaler, sample and conversion sequencer
`timescale 1ns/1ps
module actc_timing
  import actc_pkg::*;
(
  input  wire logic        pclk,          // bus clock, 200 MHz
  input  wire logic        presetn,       // async reset, active low
  input  wire logic        psel,          // apb select
  input  wire logic        penable,       // apb access phase
  input  wire logic        pwrite,        // apb direction
  input  wire logic [7:0]  paddr,         // apb byte address
  input  wire logic [31:0] pwdata,        // apb write data
  output logic      [31:0] prdata,        // apb read data
  output logic             pready,        // apb ready, always high
  output logic             pslverr,       // apb error on unmapped address
  input  wire logic        breakpoint,    // debug breakpoint active
  output logic             conv_clk_en,   // one-cycle pulse per conversion clock
  output logic             sample_buf,    // first sample phase, via buffer
  output logic             sample_direct, // second sample phase, direct
  output logic             converting,    // conversion phase
  output logic             low_resolution,// eight-bit mode to analog core
  output logic             conv_done      // pulse at end of each conversion
);
  // --------------------------------------------------------------------------
  // register bus
  // --------------------------------------------------------------------------
  logic [7:0]  timing_q;
  logic [1:0]  halt_q;
  logic        busy_q;
  logic        halted_q;
  actc_state_t state_q;
  logic        wr;
  logic        mapped;

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == ACTC_OFS_HALT_CTRL) || (a == ACTC_OFS_TIMING_CTRL) ||
                (a == ACTC_OFS_SEQ_START) || (a == ACTC_OFS_STATUS);
  endfunction

  assign mapped  = is_mapped(paddr);
  assign wr      = psel && penable && pwrite && mapped;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timing_q <= ACTC_TIMING_RESET;
    end else if (wr && paddr == ACTC_OFS_TIMING_CTRL) begin
      timing_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halt_q <= ACTC_HALT_RESET;
    end else if (wr && paddr == ACTC_OFS_HALT_CTRL) begin
      halt_q <= pwdata[1:0];
    end
  end

  always_comb begin
    prdata = 32'h0;
    if (psel && !pwrite) begin
      unique case (paddr)
        ACTC_OFS_HALT_CTRL:   prdata = {30'h0, halt_q};
        ACTC_OFS_TIMING_CTRL: prdata = {24'h0, timing_q};
        ACTC_OFS_STATUS:      prdata = {28'h0, halted_q, busy_q, state_q};
        default:              prdata = 32'h0;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // prescaler
  // --------------------------------------------------------------------------
  // counting bus cycles up to 2*(prs+1) keeps everything on pclk
  logic [5:0] div_q;
  logic [5:0] div_last;
  assign div_last = {timing_q[ACTC_PRS_HI:0], 1'b1};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 6'h0;
    end else if (div_q >= div_last) begin
      div_q <= 6'h0;
    end else begin
      div_q <= div_q + 6'h1;
    end
  end

  assign conv_clk_en = (div_q >= div_last);

  // --------------------------------------------------------------------------
  // sequencer
  // --------------------------------------------------------------------------
  logic       start_wr;
  logic       abort_wr;
  logic [4:0] cnt_q;
  logic [4:0] smp2_len;
  logic [4:0] conv_len;
  logic       freeze;

  assign start_wr = wr && paddr == ACTC_OFS_SEQ_START;
  assign abort_wr = wr && paddr == ACTC_OFS_TIMING_CTRL;
  // 2 << smp gives 2, 4, 8, 16
  assign smp2_len = 5'(5'h02 << timing_q[ACTC_SMP_HI:ACTC_SMP_LO]);
  assign conv_len = timing_q[ACTC_RES_BIT] ? ACTC_CONV_EIGHT : ACTC_CONV_TEN;
  assign low_resolution = timing_q[ACTC_RES_BIT];

  // finish-then-halt lets the conversion run out; it freezes at the next start
  always_comb begin
    freeze = 1'b0;
    if (breakpoint) begin
      unique case (halt_q)
        ACTC_HALT_NOW:    freeze = 1'b1;
        ACTC_HALT_FINISH: freeze = (state_q == ACTC_SAMP1) && cnt_q == 5'h0;
        default:          freeze = 1'b0; // continue, reserved also continues
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q   <= ACTC_IDLE;
      cnt_q     <= 5'h0;
      busy_q    <= 1'b0;
      conv_done <= 1'b0;
    end else begin
      conv_done <= 1'b0;
      if (abort_wr) begin
        state_q <= ACTC_IDLE;
        cnt_q   <= 5'h0;
        busy_q  <= 1'b0;
      end else if (start_wr) begin
        state_q <= ACTC_SAMP1;
        cnt_q   <= 5'h0;
        busy_q  <= 1'b1;
      end else if (conv_clk_en && !freeze) begin
        unique case (state_q)
          ACTC_IDLE: begin
            cnt_q <= 5'h0;
          end
          ACTC_SAMP1: begin
            if (cnt_q == ACTC_FIRST_PHASE - 5'h1) begin
              state_q <= ACTC_SAMP2;
              cnt_q   <= 5'h0;
            end else begin
              cnt_q <= cnt_q + 5'h1;
            end
          end
          ACTC_SAMP2: begin
            if (cnt_q == smp2_len - 5'h1) begin
              state_q <= ACTC_CONV;
              cnt_q   <= 5'h0;
            end else begin
              cnt_q <= cnt_q + 5'h1;
            end
          end
          ACTC_CONV: begin
            if (cnt_q == conv_len - 5'h1) begin
              state_q   <= ACTC_SAMP1; // next conversion of the sequence
              cnt_q     <= 5'h0;
              conv_done <= 1'b1;
            end else begin
              cnt_q <= cnt_q + 5'h1;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halted_q <= 1'b0;
    end else begin
      halted_q <= freeze && busy_q;
    end
  end

  assign sample_buf    = (state_q == ACTC_SAMP1);
  assign sample_direct = (state_q == ACTC_SAMP2);
  assign converting    = (state_q == ACTC_CONV);

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  // a separate table for the second phase, so the check does not reuse the shift it guards
  logic [4:0] smp2_ref;
  always_comb begin
    smp2_ref = 5'h02;
    unique case (timing_q[ACTC_SMP_HI:ACTC_SMP_LO])
      2'h0: smp2_ref = 5'h02;
      2'h1: smp2_ref = 5'h04;
      2'h2: smp2_ref = 5'h08;
      2'h3: smp2_ref = 5'h10;
    endcase
  end

  sequence s_tc_write;
    psel && penable && pwrite && paddr == ACTC_OFS_TIMING_CTRL;
  endsequence

  sequence s_quiet_bus;
    !(psel && penable && pwrite);
  endsequence

  property p_abort;
    @(posedge pclk) disable iff (!presetn) s_tc_write |=> state_q == ACTC_IDLE && !busy_q;
  endproperty
  a_abort: assert property (p_abort) else $error("timing write did not abort");

  property p_abort_stays;
    @(posedge pclk) disable iff (!presetn) s_tc_write ##1 s_quiet_bus |=> state_q == ACTC_IDLE && !busy_q;
  endproperty
  a_abort_stays: assert property (p_abort_stays) else $error("timing write let a sequence start");

  property p_reset_prs;
    @(posedge pclk) $rose(presetn) |-> timing_q[ACTC_PRS_HI:0] == 5'h05;
  endproperty
  a_reset_prs: assert property (p_reset_prs) else $error("prescale reset wrong");

  property p_pulse_single;
    @(posedge pclk) disable iff (!presetn) conv_clk_en |=> !conv_clk_en;
  endproperty
  a_pulse_single: assert property (p_pulse_single) else $error("enable wider than one cycle");

  property p_div_period;
    @(posedge pclk) disable iff (!presetn)
      (conv_clk_en && timing_q[ACTC_PRS_HI:0] == 5'h0 && !wr) ##1 !wr |-> !conv_clk_en ##1 conv_clk_en;
  endproperty
  a_div_period: assert property (p_div_period) else $error("divide by two period wrong");

  property p_res;
    @(posedge pclk) disable iff (!presetn) low_resolution == timing_q[ACTC_RES_BIT];
  endproperty
  a_res: assert property (p_res) else $error("resolution select mismatch");

  property p_freeze_now;
    @(posedge pclk) disable iff (!presetn)
      (breakpoint && halt_q == ACTC_HALT_NOW && !wr) |=> $stable(state_q) && $stable(cnt_q);
  endproperty
  a_freeze_now: assert property (p_freeze_now) else $error("immediate halt did not hold");

  property p_start;
    @(posedge pclk) disable iff (!presetn)
      (psel && penable && pwrite && paddr == ACTC_OFS_SEQ_START) |=> sample_buf && cnt_q == 5'h0;
  endproperty
  a_start: assert property (p_start) else $error("conversion did not begin with sampling");

  property p_samp1_to_2;
    @(posedge pclk) disable iff (!presetn)
      (sample_buf && conv_clk_en && !freeze && cnt_q == 5'h1 && !wr) |=> sample_direct && cnt_q == 5'h0;
  endproperty
  a_samp1_to_2: assert property (p_samp1_to_2) else $error("first phase not two clocks");

  property p_samp2_len;
    @(posedge pclk) disable iff (!presetn)
      (sample_direct && conv_clk_en && !freeze && !wr && cnt_q == smp2_ref - 5'h1) |=> converting;
  endproperty
  a_samp2_len: assert property (p_samp2_len) else $error("second phase length wrong");

  property p_continue;
    @(posedge pclk) disable iff (!presetn) (halt_q == ACTC_HALT_GO) |-> !freeze;
  endproperty
  a_continue: assert property (p_continue) else $error("froze with continue selected");

  property p_conv_ten;
    @(posedge pclk) disable iff (!presetn)
      (converting && !low_resolution && conv_clk_en && !freeze && !wr && cnt_q == ACTC_CONV_TEN - 5'h1)
      |=> conv_done && sample_buf && cnt_q == 5'h0;
  endproperty
  a_conv_ten: assert property (p_conv_ten) else $error("ten-bit conversion length wrong");

  property p_conv_eight;
    @(posedge pclk) disable iff (!presetn)
      (converting && low_resolution && conv_clk_en && !freeze && !wr && cnt_q == ACTC_CONV_EIGHT - 5'h1)
      |=> conv_done && sample_buf && cnt_q == 5'h0;
  endproperty
  a_conv_eight: assert property (p_conv_eight) else $error("eight-bit conversion length wrong");

  property p_finish_runs;
    @(posedge pclk) disable iff (!presetn)
      (breakpoint && halt_q == ACTC_HALT_FINISH && converting && conv_clk_en && !wr) |=> !$stable(cnt_q);
  endproperty
  a_finish_runs: assert property (p_finish_runs) else $error("finish-then-halt stopped mid conversion");

  property p_finish_stop;
    @(posedge pclk) disable iff (!presetn)
      (breakpoint && halt_q == ACTC_HALT_FINISH && sample_buf && cnt_q == 5'h0 && busy_q && !wr)
      |=> sample_buf && cnt_q == 5'h0 && halted_q;
  endproperty
  a_finish_stop: assert property (p_finish_stop) else $error("finish-then-halt did not hold");

  property p_reserved;
    @(posedge pclk) disable iff (!presetn) (breakpoint && halt_q == 2'h1) |-> !freeze;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved halt code froze");

  property p_breakpoint_gate;
    @(posedge pclk) disable iff (!presetn) !breakpoint |-> !freeze;
  endproperty
  a_breakpoint_gate: assert property (p_breakpoint_gate) else $error("froze without breakpoint");

  property p_enable_only;
    @(posedge pclk) disable iff (!presetn)
      (!conv_clk_en && !wr) |=> $stable(state_q) && $stable(cnt_q);
  endproperty
  a_enable_only: assert property (p_enable_only) else $error("sequencer moved without enable");

  property p_first_phase_hold;
    @(posedge pclk) disable iff (!presetn)
      (sample_buf && conv_clk_en && !freeze && !wr && cnt_q == 5'h0) |=> sample_buf && cnt_q == 5'h1;
  endproperty
  a_first_phase_hold: assert property (p_first_phase_hold) else $error("first phase ended early");
endmodule // actc_timing

// ==== rtl/actc_pkg.sv ====
// package for the converter timing control block: register map, fields, timing
// ----------------------------------------------------------------------------
// Summary of operation
// - on breakpoint: 00 continue, 10 finish conversion then halt, 11 halt now, 01 reserved
// - any timing control write aborts the running sequence, never starts one
// - bit 7 picks resolution: 0 ten-bit, 1 shorter eight-bit conversions
// - sample window: two conversion clocks via buffer, then programmable direct phase
// - bits 6:5 set second sample phase: 2, 4, 8 or 16 conversion clocks
// - bits 4:0 prescale: conversion clock is bus clock over (prescale+1), halved
// - prescale resets to 5, conversion clock is bus clock over 12
// - halt response sits in bits 1:0 of the preceding register, used only at breakpoint
// - a conversion starts when its sample phase begins; timing counts from there
// ----------------------------------------------------------------------------
package actc_pkg;
  localparam logic [7:0] ACTC_OFS_HALT_CTRL   = 8'h03; // holds the halt response field
  localparam logic [7:0] ACTC_OFS_TIMING_CTRL = 8'h04;
  localparam logic [7:0] ACTC_OFS_SEQ_START   = 8'h05;
  localparam logic [7:0] ACTC_OFS_STATUS      = 8'h08;
  localparam int ACTC_RES_BIT  = 7;
  localparam int ACTC_SMP_HI   = 6;
  localparam int ACTC_SMP_LO   = 5;
  localparam int ACTC_PRS_HI   = 4;
  localparam logic [7:0] ACTC_TIMING_RESET = 8'h05;
  localparam logic [1:0] ACTC_HALT_RESET   = 2'h0;
  localparam logic [4:0] ACTC_FIRST_PHASE  = 5'h02;
  localparam logic [4:0] ACTC_CONV_TEN     = 5'h0a; // conversion clocks per ten-bit result
  localparam logic [4:0] ACTC_CONV_EIGHT   = 5'h08;
  localparam logic [1:0] ACTC_HALT_GO      = 2'h0;
  localparam logic [1:0] ACTC_HALT_FINISH  = 2'h2;
  localparam logic [1:0] ACTC_HALT_NOW     = 2'h3;
  typedef enum logic [1:0] {ACTC_IDLE, ACTC_SAMP1, ACTC_SAMP2, ACTC_CONV} actc_state_t;
endpackage

// ==== dv/actc_core_model.sv ====
// behavioural analog core: measures phase lengths and divider period
`timescale 1ns/1ps
module actc_core_model (
  input  wire logic        pclk,          // bus clock
  input  wire logic        presetn,       // async reset, active low
  input  wire logic        conv_clk_en,   // conversion clock pulse
  input  wire logic        sample_buf,    // buffered sample phase
  input  wire logic        sample_direct, // direct sample phase
  input  wire logic        converting,    // conversion phase
  input  wire logic        conv_done,     // end of conversion
  output logic      [31:0] rec            // buffer, direct, convert lengths, period
);
  logic [7:0] buf_q, dir_q, cnv_q, per_q, gap_q;
  assign rec = {buf_q, dir_q, cnv_q, per_q};
  // counts clear at each conv_done and while idle so partial aborted runs never leak in
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {buf_q, dir_q, cnv_q} <= '0;
    end else if (conv_done || !(sample_buf || sample_direct || converting)) begin
      {buf_q, dir_q, cnv_q} <= '0;
    end else if (conv_clk_en) begin
      buf_q <= buf_q + 8'(sample_buf);
      dir_q <= dir_q + 8'(sample_direct);
      cnv_q <= cnv_q + 8'(converting);
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_q <= 8'h01;
      per_q <= 8'h00;
    end else if (conv_clk_en) begin
      per_q <= gap_q;
      gap_q <= 8'h01;
    end else begin
      gap_q <= gap_q + 8'h01;
    end
  end
endmodule // actc_core_model

// ==== dv/adc_conversion_timing_control_bench.sv ====
// self-checking bench for the converter timing control block
`timescale 1ns/1ps
module adc_conversion_timing_control_bench;
  import actc_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, breakpoint = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, rec, exp_v;
  logic pready, pslverr, err, conv_clk_en, sample_buf, sample_direct, converting, low_resolution, conv_done;
  logic [31:0] exp_q[$];
  logic [4:0] prs;
  logic [1:0] smp;
  int bad_count = 0, check_count = 0, cyc = 0, dones = 0, seed = 18, n;
  bit chk_on = 1;
  always #2.5 pclk = ~pclk;
  actc_timing i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .breakpoint(breakpoint), .conv_clk_en(conv_clk_en), .sample_buf(sample_buf),
    .sample_direct(sample_direct), .converting(converting), .low_resolution(low_resolution),
    .conv_done(conv_done));
  actc_core_model i_core (.pclk(pclk), .presetn(presetn), .conv_clk_en(conv_clk_en), .sample_buf(sample_buf),
    .sample_direct(sample_direct), .converting(converting), .conv_done(conv_done), .rec(rec));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] want);
    check_count++;
    if (got !== want) begin
      bad_count++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, want);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // a done with no note pending means a conversion the bench never started
  always @(posedge pclk) begin
    cyc++;
    if (conv_done === 1'b1) begin
      dones++;
      if (chk_on) begin
        exp_v = exp_q.size() ? exp_q.pop_front() : 32'hffffffff;
        chk(rec, exp_v);
      end
    end
    if (cyc == 60000) begin
      bad_count++;
      wrap_up;
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, ACTC_OFS_TIMING_CTRL, 32'h0);
    chk(rd, 32'h05);
    chk({31'h0, err}, 32'h0);
    chk({31'h0, pready}, 32'h1);
    apb(0, ACTC_OFS_HALT_CTRL, 32'h0);
    chk(rd, 32'h0);
    apb(1, 8'h0c, 32'hff);
    chk({31'h0, err}, 32'h1);
    apb(0, 8'h0c, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    // bench clock is far above the converter band, so small prescales keep runs short;
    // the last pass uses the slowest divider, the nearest this bus clock gets to the band
    for (int i = 0; i < 9; i++) begin
      smp = i[1:0];
      prs = (i == 8) ? 5'h1f : 5'($unsigned($random(seed)) % 4);
      apb(1, ACTC_OFS_TIMING_CTRL, {24'h0, i[2], smp, prs});
      apb(0, ACTC_OFS_STATUS, 32'h0);
      chk(rd, 32'h0);
      chk({31'h0, low_resolution}, {31'h0, i[2]});
      exp_q.push_back({8'h02, 8'(2 << smp), i[2] ? 8'h08 : 8'h0a, 8'(2 * (prs + 1))});
      apb(1, ACTC_OFS_SEQ_START, 32'h0);
      n = 0;
      while (conv_done !== 1'b1 && n < 2000) begin @(posedge pclk); n++; end
      apb(1, ACTC_OFS_TIMING_CTRL, {24'h0, i[2], smp, prs});
      apb(0, ACTC_OFS_STATUS, 32'h0);
      chk(rd, 32'h0);
    end
    apb(1, ACTC_OFS_SEQ_START, 32'h0);
    repeat (20) @(posedge pclk);
    apb(1, ACTC_OFS_TIMING_CTRL, 32'h0);
    repeat (400) @(posedge pclk);
    chk({29'h0, sample_buf, sample_direct, converting}, 32'h0);
    chk_on = 0;
    for (int m = 0; m < 4; m++) begin
      apb(1, ACTC_OFS_HALT_CTRL, m);
      apb(1, ACTC_OFS_SEQ_START, 32'h0);
      n = 0;
      while (converting !== 1'b1 && n < 500) begin @(posedge pclk); n++; end
      breakpoint <= 1'b1;
      dones = 0;
      repeat (300) @(posedge pclk);
      apb(0, ACTC_OFS_STATUS, 32'h0);
      if (m == 3) chk({dones[28:0], rd[3], rd[1:0]}, {29'h0, 1'b1, 2'h3});
      else if (m == 2) chk({dones[28:0], rd[3], rd[1:0]}, {29'h1, 1'b1, 2'h1});
      else chk(32'(dones >= 5), 32'h1);
      breakpoint <= 1'b0;
      apb(1, ACTC_OFS_TIMING_CTRL, 32'h0);
    end
    chk(32'(exp_q.size()), 32'h0);
    wrap_up;
  end
endmodule // adc_conversion_timing_control_bench
